// ===== core/wtc_regs.sv
// Wake oscillator trim, calibration and clock recovery register bank.
// Assumes a synchronous register port from the serial interface decode,
// one-cycle write strobe, and a synchronous falling-edge spacing input.
`default_nettype none
module wtc_regs
    import wtc_pkg::*;
(
    // Clock and reset.
    input  wire  logic        i_clk,
    input  wire  logic        i_nrst,
    // Register port.
    input  wire  logic        i_wr,
    input  wire  logic [6:0]  i_addr,
    input  wire  logic [15:0] i_wdata,
    output logic        [15:0] o_rdata,
    // Trim unlock field and calibration source.
    input  wire  logic [1:0]  i_trim_unlock,
    input  wire  logic        i_cal_load,
    input  wire  logic [15:0] i_cal_value,
    // Falling-edge spacing, in bits, with its valid strobe.
    input  wire  logic        i_gap_valid,
    input  wire  logic [3:0]  i_gap_bits,
    // Outputs to the wake receiver, oscillator and recovery logic.
    output logic              o_wake_receiver_select,
    output logic        [4:0] o_temp_coef,
    output logic        [6:0] o_oscillator_coarse_adjust,
    output logic              o_recovery_enable,
    output logic        [1:0] o_recovery_clock_select,
    output logic              o_recovery_clk_en,
    output logic        [5:0] o_time_constant,
    output logic        [7:0] o_bit_time_upper_limit,
    output logic        [7:0] o_bit_time_lower_limit
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] trim;    // Trim register, masked.
        logic [15:0] cal;     // Calibration readback.
        logic [15:0] rctl;    // Recovery control, masked.
        logic [15:0] limit;   // Bit-time limits.
        logic [5:0]  adapt;   // Last adaptive time constant.
        logic [2:0]  div;     // Recovery clock divider.
        logic        clk_en;  // Recovery clock enable pulse.
        logic [5:0]  tcon;    // Filter time constant in use.
        logic [15:0] rdata;   // Read data register.
    } wtc_state_t;

    wtc_state_t st;       // Registered state.
    wtc_state_t next_st;  // Next state.
    // The release stages sit outside the state struct: they run off the
    // raw reset, and one struct written by two processes has two drivers.
    logic [1:0] rst_sync; // Reset release stages, first stage in bit 0.
    logic       rst_n;    // Released reset.

    assign rst_n = rst_sync[1];

    // Map a spacing in bits onto a filter constant; out of range keeps it.
    function automatic logic [5:0] wtc_gap_tc(input logic [3:0] gap,
                                              input logic [5:0] prev);
        if (gap < 4'h2 || gap > GAP_MAX)
            return prev;
        else if (gap < GAP_MID)
            return TC_32;
        else if (gap < GAP_LONG)
            return TC_16;
        else
            return TC_8;
    endfunction

    // Divide ratio for the clock select, as a terminal count.
    function automatic logic [2:0] wtc_div_top(input logic [1:0] sel);
        return 3'((DIV_FAST << sel) - 4'h1);
    endfunction

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // Reads see the same register masks, so reserved bits stay zero.
    always_comb
    begin
        next_st = st;
        if (i_wr && i_addr == ADDR_TRIM && i_trim_unlock == UNLOCK_KEY)
        begin
            next_st.trim = i_wdata & TRIM_MASK;
        end
        // Locked writes fall through and the trim holds.
        if (i_wr && i_addr == ADDR_RCTL)
        begin
            next_st.rctl = i_wdata & RCTL_MASK;
        end
        if (i_wr && i_addr == ADDR_LIMIT)
        begin
            next_st.limit = i_wdata;
        end
        if (i_cal_load)
        begin
            next_st.cal = i_cal_value;
        end
        if (i_gap_valid)
        begin
            next_st.adapt = wtc_gap_tc(i_gap_bits, st.adapt);
        end
        // The divider is held in reset while recovery is off.
        next_st.clk_en = 1'b0;
        if (!st.rctl[EN_BIT])
        begin
            next_st.div = 3'h0;
        end
        else if (st.div >= wtc_div_top(st.rctl[CLK_LSB +: 2]))
        begin
            next_st.div    = 3'h0;
            next_st.clk_en = 1'b1;
        end
        else
        begin
            next_st.div = st.div + 3'h1;
        end
        // The constant is registered from the next control word and the
        // next adaptive value, so it is a flop output with no lost cycle.
        case (next_st.rctl[FILT_LSB +: 2])
            2'h0:    next_st.tcon = TC_8;
            2'h1:    next_st.tcon = TC_16;
            2'h2:    next_st.tcon = TC_32;
            default: next_st.tcon = next_st.adapt;
        endcase
        case (i_addr)
            ADDR_TRIM:  next_st.rdata = st.trim;
            ADDR_CAL:   next_st.rdata = st.cal;
            ADDR_RCTL:  next_st.rdata = st.rctl;
            ADDR_LIMIT: next_st.rdata = st.limit;
            default:    next_st.rdata = 16'h0000;
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Reset release runs off the raw reset; everything else off rst_n.
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rst_sync <= 2'h0;
        end
        else
        begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    // Bank contents take power-on values while the copy is low.
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st.trim   <= TRIM_RST;
            st.cal    <= CAL_RST;
            st.rctl   <= RCTL_RST;
            st.limit  <= LIMIT_RST;
            st.adapt  <= TC_16;
            st.tcon   <= TC_16;
            st.div    <= 3'h0;
            st.clk_en <= 1'b0;
            st.rdata  <= 16'h0000;
        end
        else
        begin
            st.trim   <= next_st.trim;
            st.cal    <= next_st.cal;
            st.rctl   <= next_st.rctl;
            st.limit  <= next_st.limit;
            st.adapt  <= next_st.adapt;
            st.tcon   <= next_st.tcon;
            st.div    <= next_st.div;
            st.clk_en <= next_st.clk_en;
            st.rdata  <= next_st.rdata;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_rdata                    = st.rdata;
    assign o_wake_receiver_select     = st.trim[RX_SEL_BIT];
    assign o_temp_coef                = st.trim[TC_MSB:TC_LSB];
    assign o_oscillator_coarse_adjust = st.trim[COARSE_MSB:0];
    assign o_recovery_enable          = st.rctl[EN_BIT];
    assign o_recovery_clock_select    = st.rctl[CLK_LSB +: 2];
    assign o_recovery_clk_en          = st.clk_en;
    assign o_bit_time_upper_limit     = st.limit[15:8];
    assign o_bit_time_lower_limit     = st.limit[7:0];
    assign o_time_constant            = st.tcon;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_locked_trim_holds: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        (i_wr && i_addr == ADDR_TRIM && i_trim_unlock != UNLOCK_KEY)
        |=> $stable(st.trim))
        else $error("Locked trim write changed the register.");
    a_trim_write_lands: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        (i_wr && i_addr == ADDR_TRIM && i_trim_unlock == UNLOCK_KEY)
        |=> o_temp_coef == $past(i_wdata[TC_MSB:TC_LSB]))
        else $error("Unlocked temperature trim write lost.");
    a_coarse_write_lands: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        (i_wr && i_addr == ADDR_TRIM && i_trim_unlock == UNLOCK_KEY)
        |=> o_oscillator_coarse_adjust == $past(i_wdata[6:0]))
        else $error("Unlocked coarse trim write lost.");
    a_rx_select_lands: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        (i_wr && i_addr == ADDR_TRIM && i_trim_unlock == UNLOCK_KEY)
        |=> o_wake_receiver_select == $past(i_wdata[RX_SEL_BIT]))
        else $error("Receiver select write lost.");
    a_reserved_zero: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        (i_addr == ADDR_TRIM) |=> o_rdata[15] == 1'b0 &&
        o_rdata[13:12] == 2'h0)
        else $error("Reserved trim bits read nonzero.");
    a_no_clk_disabled: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        !o_recovery_enable [*2] |-> !o_recovery_clk_en)
        else $error("Recovery clock ran while disabled.");
    a_fast_clk_each: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        (o_recovery_enable && o_recovery_clock_select == 2'h0) [*3]
        |-> o_recovery_clk_en)
        else $error("Fastest recovery clock not every cycle.");
    a_filter_map: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        st.rctl[FILT_LSB +: 2] == 2'h2 |-> o_time_constant == 6'h20)
        else $error("Filter code 10 not constant 32.");
    a_limit_write: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        (i_wr && i_addr == ADDR_LIMIT) |=>
        {o_bit_time_upper_limit, o_bit_time_lower_limit} == $past(i_wdata))
        else $error("Limit write lost.");
    a_cal_read_only: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        (!i_cal_load) |=> $stable(st.cal))
        else $error("Calibration changed without load.");
endmodule
`default_nettype wire

// ===== core/wtc_pkg.sv
// Package for the wake oscillator trim and clock recovery register bank.
// Assumes a register access port with 7-bit word addresses, 16-bit data.
`default_nettype none
package wtc_pkg;
    // ------------------------------------------------------------------
    // Register addresses (7-bit word addresses)
    // ------------------------------------------------------------------
    localparam logic [6:0] ADDR_TRIM  = 7'h3C;  // Oscillator trim.
    localparam logic [6:0] ADDR_CAL   = 7'h3D;  // Calibration readback.
    localparam logic [6:0] ADDR_RCTL  = 7'h3E;  // Recovery control.
    localparam logic [6:0] ADDR_LIMIT = 7'h3F;  // Bit-time limits.
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int RX_SEL_BIT  = 14;  // Wake receiver select.
    localparam int TC_LSB      = 7;   // Temperature coefficient field.
    localparam int TC_MSB      = 11;
    localparam int COARSE_MSB  = 6;   // Coarse oscillator adjust.
    localparam int CLK_LSB     = 5;   // Recovery clock select.
    localparam int FILT_LSB    = 2;   // Filter constant field.
    localparam int EN_BIT      = 0;   // Recovery enable.
    // ------------------------------------------------------------------
    // Masks and reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] TRIM_MASK  = 16'h4FFF;
    localparam logic [15:0] RCTL_MASK  = 16'h006D;
    localparam logic [15:0] TRIM_RST   = 16'h0000;
    localparam logic [15:0] RCTL_RST   = 16'h0004;
    localparam logic [15:0] LIMIT_RST  = 16'h9D8F;
    localparam logic [15:0] CAL_RST    = 16'h0000;
    localparam logic [1:0]  UNLOCK_KEY = 2'h3;
    // Filter codes and the time constants they pick.
    localparam logic [1:0]  FILT_ADAPT = 2'h3;
    localparam logic [5:0]  TC_8       = 6'h08;
    localparam logic [5:0]  TC_16      = 6'h10;
    localparam logic [5:0]  TC_32      = 6'h20;
    // Edge spacing bounds in bit times for the adaptive filter.
    localparam logic [3:0]  GAP_MID    = 4'h4;
    localparam logic [3:0]  GAP_LONG   = 4'h9;
    localparam logic [3:0]  GAP_MAX    = 4'hA;
    // Recovery clock divide ratios from 75 MHz (1, 2, 4, 8).
    localparam logic [3:0]  DIV_FAST   = 4'h1;
endpackage
`default_nettype wire

// ===== sim/wtc_host.sv
// Host model: drives the register port of the trim and recovery bank.
// Assumes the bench calls its tasks; one request at a time.
`default_nettype none
module wtc_host
(
    // Clock and read data.
    input  wire logic        i_clk,
    input  wire logic [15:0] i_rdata,
    // Register port toward the bank.
    output var  logic        o_wr,
    output var  logic [6:0]  o_addr,
    output var  logic [15:0] o_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // -----------------------------------------------------------------
    // Bus tasks
    // -----------------------------------------------------------------
    initial
    begin
        o_wr    = 1'b0;
        o_addr  = 7'h00;
        o_wdata = 16'h0000;
    end
    // One strobe per word; data is scrambled when idle, no kindness.
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge i_clk);
        o_wr    <= 1'b1;
        o_addr  <= a;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr    <= 1'b0;
        o_wdata <= ~d;
        @(posedge i_clk);
        #1;
    endtask
    // Read data is registered, so it lands one edge after the address.
    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        @(posedge i_clk);
        o_addr <= a;
        @(posedge i_clk);
        @(posedge i_clk);
        #1;
        d = i_rdata;
    endtask
endmodule
`default_nettype wire

// ===== sim/tb_wtc_regs.sv
// Self-checking bench for the trim and recovery register bank.
// Assumes the host model and the bank; all waits are bounded.
`default_nettype none
module tb_wtc_regs;
    import wtc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // -----------------------------------------------------------------
    // Signals
    // -----------------------------------------------------------------
    logic        i_clk, i_nrst, wr, cal_ld, gv;
    logic [6:0]  addr;
    logic [15:0] wdata, rdata, cval, r;
    logic [1:0]  unl;
    logic [3:0]  gap;
    logic        rsel, en, cen;
    logic [4:0]  tc;
    logic [6:0]  crs;
    logic [1:0]  csel;
    logic [5:0]  tcon;
    logic [7:0]  up, lo;
    int          fails = 0, checks_done = 0;
    wtc_host host (.i_clk(i_clk), .i_rdata(rdata), .o_wr(wr),
        .o_addr(addr), .o_wdata(wdata));
    wtc_regs dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_wr(wr),
        .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
        .i_trim_unlock(unl), .i_cal_load(cal_ld), .i_cal_value(cval),
        .i_gap_valid(gv), .i_gap_bits(gap),
        .o_wake_receiver_select(rsel), .o_temp_coef(tc),
        .o_oscillator_coarse_adjust(crs), .o_recovery_enable(en),
        .o_recovery_clock_select(csel), .o_recovery_clk_en(cen),
        .o_time_constant(tcon), .o_bit_time_upper_limit(up),
        .o_bit_time_lower_limit(lo));
    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // Compare with case inequality so an unknown never matches.
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        checks_done++;
        if (g !== e)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // Read one register and compare it with the expected word.
    task automatic rd_chk(string n, logic [6:0] a, logic [15:0] e);
        host.rd(a, r);
        chk(n, e, r);
    endtask
    // Count clock-enable pulses over a fixed window of cycles.
    task automatic pulses(int w, output int c);
        c = 0;
        repeat (w)
        begin
            @(posedge i_clk);
            #1;
            if (cen === 1'b1) c++;
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // -----------------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------------
    task automatic t_reset;
        rd_chk("trim", ADDR_TRIM, 16'h0000);
        rd_chk("cal", ADDR_CAL, 16'h0000);
        rd_chk("rctl", ADDR_RCTL, 16'h0004);
        rd_chk("lim", ADDR_LIMIT, 16'h9D8F);
        chk("tcon", 16'h0010, 16'(tcon));
        chk("en", 16'h0000, 16'(en));
        chk("hi_lo", 16'h9D8F, {up, lo});
        chk("rsel", 16'h0000, 16'(rsel));
        $display("test reset done");
    endtask
    // Locked writes are dropped; unlocked ones keep reserved bits zero.
    task automatic t_trim;
        host.wr(ADDR_TRIM, 16'hFFFF);
        rd_chk("locked", ADDR_TRIM, 16'h0000);
        unl <= 2'h3;
        host.wr(ADDR_TRIM, 16'hFFFF);
        rd_chk("trim", ADDR_TRIM, 16'h4FFF);
        chk("rsel", 16'h0001, 16'(rsel));
        chk("tc", 16'h001F, 16'(tc));
        chk("crs", 16'h007F, 16'(crs));
        // Normal receiver picked again, with a nonzero trim left behind.
        host.wr(ADDR_TRIM, 16'h0F55);
        chk("rsel", 16'h0000, 16'(rsel));
        unl <= 2'h0;
        host.wr(ADDR_TRIM, 16'h4FFF);
        rd_chk("held", ADDR_TRIM, 16'h0F55);
        chk("tc_held", 16'h001E, 16'(tc));
        chk("crs_held", 16'h0055, 16'(crs));
        $display("test trim done");
    endtask
    // Every clock select and fixed filter code, enabled.
    task automatic t_rctl;
        int c;
        logic [5:0] k [3] = '{6'h08, 6'h10, 6'h20};
        logic [15:0] v;
        for (int i = 0; i < 4; i++)
        begin
            // Reserved bits are written as ones and must read as zero.
            v = {9'h0, 2'(i), 1'b0, 2'(i), 2'h1};
            host.wr(ADDR_RCTL, v | 16'hFF92);
            rd_chk("rctl", ADDR_RCTL, v);
            chk("en", 16'h0001, 16'(en));
            chk("csel", 16'(i), 16'(csel));
            if (i < 3)
            begin
                chk("tcon", 16'(k[i]), 16'(tcon));
            end
            pulses(64, c);
            chk("clk_en", 16'(64 >> i), 16'(c));
        end
        host.wr(ADDR_RCTL, 16'h000C);
        chk("en_off", 16'h0000, 16'(en));
        pulses(16, c);
        chk("off", 16'h0000, 16'(c));
        $display("test rctl done");
    endtask
    // Adaptive filter, including out-of-range gaps that must be kept.
    task automatic t_adapt;
        logic [3:0] g [8] = '{4'h2, 4'hB, 4'h4, 4'h1, 4'h8, 4'h9, 4'hA, 4'h3};
        logic [5:0] e [8] = '{6'h20, 6'h20, 6'h10, 6'h10, 6'h10, 6'h08,
                              6'h08, 6'h20};
        for (int i = 0; i < 8; i++)
        begin
            @(posedge i_clk);
            gv  <= 1'b1;
            gap <= g[i];
            @(posedge i_clk);
            gv  <= 1'b0;
            @(posedge i_clk);
            #1;
            chk("adapt", 16'(e[i]), 16'(tcon));
        end
        $display("test adapt done");
    endtask
    // Calibration loads from inside and ignores host writes.
    task automatic t_cal;
        @(posedge i_clk);
        cal_ld <= 1'b1;
        cval   <= 16'hA55A;
        @(posedge i_clk);
        cal_ld <= 1'b0;
        host.wr(ADDR_CAL, 16'h1234);
        rd_chk("cal", ADDR_CAL, 16'hA55A);
        host.wr(ADDR_LIMIT, 16'h4E47);
        rd_chk("lim", ADDR_LIMIT, 16'h4E47);
        chk("hi_lo", 16'h4E47, {up, lo});
        rd_chk("unmapped", 7'h40, 16'h0000);
        $display("test cal done");
    endtask
    // A reset in mid-run must bring every register back to its reset word.
    task automatic t_rerst;
        @(posedge i_clk);
        i_nrst <= 1'b0;
        repeat (3) @(posedge i_clk);
        i_nrst <= 1'b1;
        repeat (4) @(posedge i_clk);
        t_reset;
        $display("test rerst done");
    endtask
    initial
    begin
        i_nrst = 1'b0;
        unl    = 2'h0;
        cal_ld = 1'b0;
        cval   = 16'h0000;
        gv     = 1'b0;
        gap    = 4'h0;
        repeat (5) @(posedge i_clk);
        i_nrst <= 1'b1;
        repeat (4) @(posedge i_clk);
        t_reset;
        t_trim;
        t_rctl;
        t_adapt;
        t_cal;
        t_rerst;
        conclude;
    end
    // Cut a hang short.
    initial
    begin
        repeat (20000) @(posedge i_clk);
        fails++;
        conclude;
    end
endmodule
`default_nettype wire
